// >>> hdl/perf_pkg.sv
// package for the two-channel event counter unit: event codes, range codes, widths
// assumes a single 100 MHz clock domain and synchronous active-low reset
package perf_pkg;

  localparam int unsigned NUM_CHANNELS = 2;
  localparam int unsigned COUNT_WIDTH = 32;
  localparam int unsigned EVENT_WIDTH = 4;
  localparam int unsigned NUM_EVENTS = 16;

  // measurement range selection per channel
  typedef enum logic {
    RANGE_WHOLE_RUN = 1'b0,
    RANGE_WINDOW = 1'b1
  } range_t;

  // event selection codes
  localparam logic [3:0] EV_CACHEABLE_READ = 4'h0;
  localparam logic [3:0] EV_CACHEABLE_WRITE = 4'h1;
  localparam logic [3:0] EV_CACHEABLE_ACCESS = 4'h2;
  localparam logic [3:0] EV_ONCHIP_RAM = 4'h3;
  localparam logic [3:0] EV_ALL_OPERAND = 4'h4;
  localparam logic [3:0] EV_ONCHIP_IO = 4'h5;
  localparam logic [3:0] EV_OPERAND_READ_MISS = 4'h6;
  localparam logic [3:0] EV_OPERAND_WRITE_MISS = 4'h7;
  localparam logic [3:0] EV_OPERAND_ANY_MISS = 4'h8;
  localparam logic [3:0] EV_ICACHE_MISS = 4'h9;
  localparam logic [3:0] EV_DATA_TLB_MISS = 4'ha;
  localparam logic [3:0] EV_INST_TLB_MISS = 4'hb;
  localparam logic [3:0] EV_CACHEABLE_FETCH = 4'hc;
  localparam logic [3:0] EV_ALL_FETCH = 4'hd;
  localparam logic [3:0] EV_BRANCH_ISSUE = 4'he;
  localparam logic [3:0] EV_INST_ISSUE = 4'hf;

  // bit positions inside the decoded event vector
  localparam int unsigned EVB_CACHEABLE_READ = 0;
  localparam int unsigned EVB_INST_ISSUE = 15;

endpackage

// >>> hdl/perf_channel.sv
// one counting channel: range gating and a counter of selected events
// assumes the decoded event vector is one-cycle strobes on the same clock
`timescale 1ns/1ps
`default_nettype none

module perf_channel #(
  parameter int unsigned WIDTH = perf_pkg::COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic run_active,
  input wire logic window_start,
  input wire logic window_stop,
  input wire perf_pkg::range_t range_sel,
  input wire logic [perf_pkg::EVENT_WIDTH-1:0] event_sel,
  input wire logic [perf_pkg::NUM_EVENTS-1:0] events,
  output logic [WIDTH-1:0] count,
  output logic counting
);

  ////////////////////////////////////////////////////////////////////////
  logic [WIDTH-1:0] count_q, count_d;
  logic window_q, window_d;
  logic hit;

  // window opens on start trigger, closes on stop; stop wins if both in one cycle
  always_comb begin
    window_d = window_q;
    if (arm) begin
      window_d = 1'b0;
    end else if (window_stop) begin
      window_d = 1'b0;
    end else if (window_start) begin
      window_d = 1'b1;
    end
  end

  // active gate: whole run follows run state, window follows triggers
  assign counting = (range_sel == perf_pkg::RANGE_WHOLE_RUN) ? run_active
                  : (window_q && run_active);
  assign hit = events[event_sel];

  // clear on arm, then +1 per qualifying event while gated open
  always_comb begin
    count_d = count_q;
    if (arm) begin
      count_d = '0;
    end else if (counting && hit) begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_q <= '0;
      window_q <= 1'b0;
    end else begin
      count_q <= count_d;
      window_q <= window_d;
    end
  end

  assign count = count_q;

  chk_arm_clears: assert property (@(posedge clock) disable iff (!rst_n)
    arm |=> count_q == '0) else $error("count not cleared by arm");
  chk_count_step: assert property (@(posedge clock) disable iff (!rst_n)
    (!arm && counting && hit) |=> count_q == $past(count_q) + WIDTH'(1))
    else $error("count did not step");
  chk_idle_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (!arm && !(counting && hit)) |=> $stable(count_q))
    else $error("count moved while idle");
  chk_window_open: assert property (@(posedge clock) disable iff (!rst_n)
    (!arm && window_start && !window_stop) |=> window_q)
    else $error("window did not open");
  chk_window_close: assert property (@(posedge clock) disable iff (!rst_n)
    (!arm && window_stop) |=> !window_q) else $error("window did not close");

endmodule

`default_nettype wire

// >>> hdl/perf_unit.sv
// top of the event counter unit: event decode from core strobes, two channels
// assumes core strobes are one-cycle pulses synchronous to clock; host holds config
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - two independent channels count two selected events in the same run
// - each channel picks its own range: whole run or break window
// - whole-run range counts from program start until program stop
// - window range starts on break condition one, stops on condition four
// - in window range conditions one and four do not halt the program
// - cacheable read event counts cacheable operand reads with cache on
// - cacheable write event counts cacheable operand writes with cache on
// - cacheable access event counts cacheable reads and writes with cache on
// - on-chip RAM event counts each operand access to internal RAM
// - all-operand event counts every operand access
// - on-chip I/O event counts each access to internal register region
// - operand miss events: read misses, write misses, and either
// - instruction cache miss event counts each instruction cache miss
// - data TLB miss event counts unified TLB misses on data access
// - instruction TLB miss event counts both TLB misses on fetches
// - cacheable fetch event counts cacheable fetches with cache on
// - all-fetch event counts every instruction fetch
// - branch event counts listed branch kinds, excluding zero-displacement conditionals
// - a pair of instructions issued together counts as one issue
module perf_unit #(
  parameter int unsigned WIDTH = perf_pkg::COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic run_active,
  input wire logic brk1_match,
  input wire logic brk4_match,
  input wire perf_pkg::range_t range_sel_0,
  input wire perf_pkg::range_t range_sel_1,
  input wire logic [perf_pkg::EVENT_WIDTH-1:0] event_sel_0,
  input wire logic [perf_pkg::EVENT_WIDTH-1:0] event_sel_1,
  input wire logic operand_valid,
  input wire logic operand_write,
  input wire logic operand_cacheable,
  input wire logic cache_enabled,
  input wire logic operand_ram,
  input wire logic io_access,
  input wire logic operand_miss,
  input wire logic icache_miss,
  input wire logic unified_translation_buffer_miss_data,
  input wire logic unified_translation_buffer_miss_inst,
  input wire logic instruction_translation_buffer_miss,
  input wire logic fetch_valid,
  input wire logic fetch_cacheable,
  input wire logic branch_issue,
  input wire logic branch_conditional,
  input wire logic branch_zero_disp,
  input wire logic issue_valid,
  output logic [WIDTH-1:0] count_0,
  output logic [WIDTH-1:0] count_1,
  output logic counting_0,
  output logic counting_1,
  output logic brk1_halt,
  output logic brk4_halt
);

  ////////////////////////////////////////////////////////////////////////
  // event decode, registered so every strobe has the same one-cycle latency
  logic [perf_pkg::NUM_EVENTS-1:0] ev_q, ev_d;
  logic cached_op;

  always_comb begin
    cached_op = operand_valid && operand_cacheable && cache_enabled;
    ev_d = '0;
    ev_d[perf_pkg::EV_CACHEABLE_READ] = cached_op && !operand_write;
    ev_d[perf_pkg::EV_CACHEABLE_WRITE] = cached_op && operand_write;
    ev_d[perf_pkg::EV_CACHEABLE_ACCESS] = cached_op;
    ev_d[perf_pkg::EV_ONCHIP_RAM] = operand_valid && operand_ram;
    ev_d[perf_pkg::EV_ALL_OPERAND] = operand_valid;
    ev_d[perf_pkg::EV_ONCHIP_IO] = io_access;
    ev_d[perf_pkg::EV_OPERAND_READ_MISS] = operand_miss && !operand_write;
    ev_d[perf_pkg::EV_OPERAND_WRITE_MISS] = operand_miss && operand_write;
    ev_d[perf_pkg::EV_OPERAND_ANY_MISS] = operand_miss;
    ev_d[perf_pkg::EV_ICACHE_MISS] = icache_miss;
    ev_d[perf_pkg::EV_DATA_TLB_MISS] = unified_translation_buffer_miss_data;
    // either buffer missing on a fetch counts once, not twice
    ev_d[perf_pkg::EV_INST_TLB_MISS] = unified_translation_buffer_miss_inst || instruction_translation_buffer_miss;
    ev_d[perf_pkg::EV_CACHEABLE_FETCH] = fetch_valid && fetch_cacheable
                                         && cache_enabled;
    ev_d[perf_pkg::EV_ALL_FETCH] = fetch_valid;
    // conditional branches with zero displacement are excluded
    ev_d[perf_pkg::EV_BRANCH_ISSUE] = branch_issue
                                      && !(branch_conditional && branch_zero_disp);
    // one strobe per issue slot cycle, so a dual issue is a single count
    ev_d[perf_pkg::EV_INST_ISSUE] = issue_valid;
  end

  ////////////////////////////////////////////////////////////////////////
  // delayed copies of control so channel gating lines up with the decoded events
  logic run_q, run_d, brk1_q, brk1_d, brk4_q, brk4_d, arm_q, arm_d;
  logic halt1_q, halt1_d, halt4_q, halt4_d;
  logic win_any;

  assign win_any = (range_sel_0 == perf_pkg::RANGE_WINDOW)
                || (range_sel_1 == perf_pkg::RANGE_WINDOW);

  always_comb begin
    run_d = run_active;
    brk1_d = brk1_match;
    brk4_d = brk4_match;
    arm_d = arm;
    // break matches halt only when no channel uses them as triggers
    halt1_d = brk1_match && !win_any;
    halt4_d = brk4_match && !win_any;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ev_q <= '0;
      run_q <= 1'b0;
      brk1_q <= 1'b0;
      brk4_q <= 1'b0;
      arm_q <= 1'b0;
      halt1_q <= 1'b0;
      halt4_q <= 1'b0;
    end else begin
      ev_q <= ev_d;
      run_q <= run_d;
      brk1_q <= brk1_d;
      brk4_q <= brk4_d;
      arm_q <= arm_d;
      halt1_q <= halt1_d;
      halt4_q <= halt4_d;
    end
  end

  assign brk1_halt = halt1_q;
  assign brk4_halt = halt4_q;

  ////////////////////////////////////////////////////////////////////////
  // two channels; counts come from the channel flip-flops, gates are combinational from window_q and run_q
  // note: window runs rely on the host having set both triggers beforehand
  logic [WIDTH-1:0] cnt [perf_pkg::NUM_CHANNELS];
  logic [perf_pkg::NUM_CHANNELS-1:0] gate;
  perf_pkg::range_t rsel [perf_pkg::NUM_CHANNELS];
  logic [perf_pkg::EVENT_WIDTH-1:0] esel [perf_pkg::NUM_CHANNELS];
  logic [perf_pkg::NUM_CHANNELS-1:0] gate_q, gate_d;

  assign rsel[0] = range_sel_0;
  assign rsel[1] = range_sel_1;
  assign esel[0] = event_sel_0;
  assign esel[1] = event_sel_1;

  for (genvar ch = 0; ch < perf_pkg::NUM_CHANNELS; ch++) begin : g_chan
    perf_channel #(.WIDTH(WIDTH)) u_chan (
      .clock(clock),
      .rst_n(rst_n),
      .arm(arm_q),
      .run_active(run_q),
      .window_start(brk1_q),
      .window_stop(brk4_q),
      .range_sel(rsel[ch]),
      .event_sel(esel[ch]),
      .events(ev_q),
      .count(cnt[ch]),
      .counting(gate[ch])
    );
  end

  // counting flags registered so the outputs come from flip-flops
  always_comb begin
    gate_d = gate;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gate_q <= '0;
    end else begin
      gate_q <= gate_d;
    end
  end

  assign count_0 = cnt[0];
  assign count_1 = cnt[1];
  assign counting_0 = gate_q[0];
  assign counting_1 = gate_q[1];

  ////////////////////////////////////////////////////////////////////////
  chk_no_halt_window: assert property (@(posedge clock) disable iff (!rst_n)
    (brk1_match && win_any) |=> !brk1_halt) else $error("break halted in window");
  chk_halt_passes: assert property (@(posedge clock) disable iff (!rst_n)
    (brk4_match && !win_any) |=> brk4_halt) else $error("break halt lost");
  chk_read_excl: assert property (@(posedge clock) disable iff (!rst_n)
    operand_write |=> !ev_q[perf_pkg::EV_CACHEABLE_READ])
    else $error("write counted as read");
  chk_write_excl: assert property (@(posedge clock) disable iff (!rst_n)
    (operand_valid && !operand_write) |=> !ev_q[perf_pkg::EV_CACHEABLE_WRITE])
    else $error("read counted as write");
  chk_cache_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !cache_enabled |=> !ev_q[perf_pkg::EV_CACHEABLE_ACCESS] && !ev_q[perf_pkg::EV_CACHEABLE_FETCH])
    else $error("cache-off counted");
  chk_zero_disp: assert property (@(posedge clock) disable iff (!rst_n)
    (branch_conditional && branch_zero_disp) |=> !ev_q[perf_pkg::EV_BRANCH_ISSUE])
    else $error("zero displacement branch counted");
  chk_instruction_translation_buffer_any: assert property (@(posedge clock) disable iff (!rst_n)
    (instruction_translation_buffer_miss || unified_translation_buffer_miss_inst) |=> ev_q[perf_pkg::EV_INST_TLB_MISS])
    else $error("fetch tlb miss lost");
  // judged against the raw run input one cycle back, so a broken run stage shows up
  chk_whole_gate: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(rst_n) && range_sel_0 == perf_pkg::RANGE_WHOLE_RUN && $stable(range_sel_0))
    |-> gate[0] == $past(run_active))
    else $error("whole-run gate wrong");

endmodule

`default_nettype wire

// >>> test/core_model.sv
// stand-in for the processor core strobes and the debug host break matches
// assumes the unit's clock is shared; every change lands on a falling edge
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input wire logic clock,
  output logic [18:0] lines
);
  logic [18:0] mix_tab [0:16];

  ////////////////////////////////////////////////////////////////////////////////
  // one entry per access kind; qualifier levels ride with the strobe and then drop
  initial begin
    lines = '0;
    mix_tab = '{19'h0000d, 19'h0000f, 19'h00005, 19'h00011, 19'h00020, 19'h00040,
                19'h00042, 19'h00080, 19'h00100, 19'h00200, 19'h00400, 19'h01808,
                19'h01800, 19'h02000, 19'h06000, 19'h0e000, 19'h10000};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // single one-cycle pulse; lines go back to zero so no stale level lingers
  task automatic strobe(input logic [18:0] v);
    @(negedge clock);
    lines = v;
    @(negedge clock);
    lines = '0;
  endtask

  // all kinds back to back, one per cycle, so a dropped neighbour shows up
  task automatic mix();
    for (int i = 0; i < 17; i++) begin
      @(negedge clock);
      lines = mix_tab[i];
    end
    @(negedge clock);
    lines = '0;
  endtask
endmodule

`default_nettype wire

// >>> test/cpu_event_perf_counters_bench.sv
// self-checking bench for the two-channel event counter unit
// assumes core_model drives core strobes; bench drives config on falling edges
`timescale 1ns/1ps
`default_nettype none

module cpu_event_perf_counters_bench;
  logic clock, rst_n, arm, run_active;
  perf_pkg::range_t range_sel_0, range_sel_1;
  logic [3:0] event_sel_0, event_sel_1;
  logic [18:0] core;
  logic [31:0] count_0, count_1;
  logic counting_0, counting_1, brk1_halt, brk4_halt;
  int miscompares = 0;
  int comparisons = 0;
  int h1_seen = 0;
  int h4_seen = 0;
  int unsigned exp_tab [0:15] = '{1, 1, 2, 1, 4, 1, 1, 1, 2, 1, 1, 2, 1, 2, 2, 1};

  core_model i_core (.clock(clock), .lines(core));

  perf_unit i_dut (.clock(clock), .rst_n(rst_n), .arm(arm), .run_active(run_active),
    .brk1_match(core[17]), .brk4_match(core[18]), .range_sel_0(range_sel_0),
    .range_sel_1(range_sel_1), .event_sel_0(event_sel_0), .event_sel_1(event_sel_1),
    .operand_valid(core[0]), .operand_write(core[1]), .operand_cacheable(core[2]),
    .cache_enabled(core[3]), .operand_ram(core[4]), .io_access(core[5]),
    .operand_miss(core[6]), .icache_miss(core[7]), .unified_translation_buffer_miss_data(core[8]),
    .unified_translation_buffer_miss_inst(core[9]), .instruction_translation_buffer_miss(core[10]), .fetch_valid(core[11]),
    .fetch_cacheable(core[12]), .branch_issue(core[13]), .branch_conditional(core[14]),
    .branch_zero_disp(core[15]), .issue_valid(core[16]), .count_0(count_0),
    .count_1(count_1), .counting_0(counting_0), .counting_1(counting_1),
    .brk1_halt(brk1_halt), .brk4_halt(brk4_halt));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, and halt pulses tallied away from the edge that launches them
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(negedge clock) begin
    if (brk1_halt === 1'b1) h1_seen++;
    if (brk4_halt === 1'b1) h4_seen++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // arm with a chosen setup; the program is left stopped so callers decide when it runs
  task automatic new_run(input perf_pkg::range_t r0, input perf_pkg::range_t r1,
                         input logic [3:0] s0, input logic [3:0] s1);
    @(negedge clock);
    range_sel_0 = r0;
    range_sel_1 = r1;
    event_sel_0 = s0;
    event_sel_1 = s1;
    arm = 1'b1;
    @(negedge clock);
    arm = 1'b0;
    repeat (3) @(negedge clock);
    check("count_0 after arm", 32'h0, count_0);
    check("count_1 after arm", 32'h0, count_1);
    h1_seen = 0;
    h4_seen = 0;
  endtask

  // a run is one continuous go, never stepped, so the whole-run figure is usable
  task automatic end_run();
    repeat (4) @(negedge clock);
    run_active = 1'b0;
    repeat (2) @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check("count_0 at reset", 32'h0, count_0);
    check("count_1 at reset", 32'h0, count_1);
    check("halts at reset", 32'h0, {30'h0, brk1_halt, brk4_halt});
  endtask

  // every event code on channel 0, its mirror code on channel 1 in the same run
  task automatic test_events();
    for (int c = 0; c < 16; c++) begin
      new_run(perf_pkg::RANGE_WHOLE_RUN, perf_pkg::RANGE_WHOLE_RUN, 4'(c), 4'(15 - c));
      run_active = 1'b1;
      i_core.mix();
      end_run();
      check("count_0 per code", exp_tab[c], count_0);
      check("count_1 per code", exp_tab[15 - c], count_1);
    end
  endtask

  // window on channel 0 against whole run on channel 1, with a start and stop collision
  task automatic test_window();
    new_run(perf_pkg::RANGE_WINDOW, perf_pkg::RANGE_WHOLE_RUN, 4'h4, 4'h4);
    run_active = 1'b1;
    i_core.mix();
    i_core.strobe(19'h60000);
    repeat (3) @(negedge clock);
    i_core.mix();
    i_core.strobe(19'h20000);
    repeat (3) @(negedge clock);
    check("counting_0 in window", 32'h1, {31'h0, counting_0});
    check("counting_1 whole run", 32'h1, {31'h0, counting_1});
    i_core.mix();
    i_core.strobe(19'h40000);
    repeat (3) @(negedge clock);
    check("counting_0 after stop", 32'h0, {31'h0, counting_0});
    i_core.mix();
    end_run();
    check("count_0 window", 32'h4, count_0);
    check("count_1 whole", 32'h10, count_1);
    check("counting_1 after run", 32'h0, {31'h0, counting_1});
    check("halts in window", 32'h0, 32'(h1_seen + h4_seen));
  endtask

  // events before the program starts are ignored; without a window, matches do halt
  task automatic test_whole_halt();
    new_run(perf_pkg::RANGE_WHOLE_RUN, perf_pkg::RANGE_WHOLE_RUN, 4'h4, 4'hd);
    i_core.mix();
    run_active = 1'b1;
    i_core.strobe(19'h20000);
    i_core.strobe(19'h40000);
    end_run();
    check("count_0 before run", 32'h0, count_0);
    check("count_1 before run", 32'h0, count_1);
    check("brk1 halt pulses", 32'h1, 32'(h1_seen));
    check("brk4 halt pulses", 32'h1, 32'(h4_seen));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    arm = 1'b0;
    run_active = 1'b0;
    range_sel_0 = perf_pkg::RANGE_WHOLE_RUN;
    range_sel_1 = perf_pkg::RANGE_WHOLE_RUN;
    event_sel_0 = 4'h0;
    event_sel_1 = 4'h0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    test_reset();
    test_events();
    test_window();
    test_whole_halt();
    give_verdict();
  end

  // the whole run needs well under 1000 cycles; this cuts a hang short
  initial begin
    #50us;
    miscompares++;
    give_verdict();
  end
endmodule

`default_nettype wire
